//--- pkg/acr_pkg.sv
// Constants, field layouts and types for the channel 1 gain / checksum bank.
// Assumes the serial frame format described in the main module header.
package acr_pkg;

  // ----------------------------------------------------------------
  // Register addresses (6-bit word address in the command word)
  // ----------------------------------------------------------------
  localparam int           ADDR_W           = 6;
  localparam logic [5:0]   ADDR_GAIN_HIGH   = 6'h11;
  localparam logic [5:0]   ADDR_GAIN_LOW    = 6'h12;
  localparam logic [5:0]   ADDR_MAP_CRC     = 6'h3e;
  localparam logic [5:0]   ADDR_SPARE       = 6'h3f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0]  RST_GAIN_HIGH    = 16'h8000;
  localparam logic [7:0]   RST_GAIN_LOW     = 8'h00;
  localparam logic [15:0]  RST_MAP_CRC      = 16'h0000;
  localparam logic [15:0]  RST_SPARE        = 16'h0000;
  localparam logic [7:0]   LOW_RSVD_VALUE   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int           LOW_FIELD_MSB    = 15;
  localparam int           LOW_FIELD_LSB    = 8;
  localparam int           CMD_WRITE_BIT    = 15;
  localparam int           CMD_ADDR_MSB     = 13;
  localparam int           CMD_ADDR_LSB     = 8;

  // ----------------------------------------------------------------
  // Frame counts and checksum
  // ----------------------------------------------------------------
  localparam int           WORD_BITS        = 16;
  localparam logic [4:0]   LAST_CMD_BIT     = 5'h0f;
  localparam logic [4:0]   LAST_FRAME_BIT   = 5'h1f;
  localparam int           SYNC_STAGES      = 2;
  localparam logic [15:0]  CRC_POLY         = 16'h1021;
  localparam logic [15:0]  CRC_SEED         = 16'hffff;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b10,
    PH_DONE = 2'b11
  } acr_phase_t;

endpackage

//--- design/acr_sync.sv
// Two-stage level synchroniser, one chain per bit.
// Assumes inputs are asynchronous to clk; only stage two is read outside.
// Chains reset to zero, so callers feed levels that idle low.
`timescale 1ns/1ps
module acr_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1_q;

  // ----------------------------------------------------------------
  // Per-bit chains
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1_q[i] <= 1'b0;
          synced[i]   <= 1'b0;
        end else begin
          stage1_q[i] <= async[i];
          synced[i]   <= stage1_q[i];
        end
      end
    end
  endgenerate

endmodule

//--- design/acr_regs.sv
// Channel 1 gain calibration, register-map checksum and spare word,
// reached over the device serial port (chip select, clock, data in/out).
// Assumes serial clock, chip select and data in come from the host,
// asynchronous to ref_clk, with the serial clock well below ref_clk / 4.
//
// Frame: chip select low, 32 clocks, data taken on falling edges, data out
// changes on rising edges. Word 1 = command: bit 15 write, bits 13:8 address.
// Word 2 = write data (write) or read data shifted out MSB first (read).
//
// Behaviour
// RL1 - High gain register holds gain bits 23:8
// RL2 - Low register: gain bits 7:0, low byte zero
// RL3 - Read-only map checksum at 3Eh, resets zero
// RL4 - Host writes only zeros to spare word
// RL5 - Data out released while chip select high
// RL6 - Host never selects two devices together
// RL7 - Host shares clock, strobes sync together
// RL8 - Lone device: host may tie select, use checksums; here a tied select gives only the first frame after reset
// RL9 - Host may count clock cycles for sampling
// RL10 - Host should wire sync or data-ready; here neither pin exists and the host paces frames by counting ref_clk cycles
// RL11 - Synchronised devices convert at the same time
// RL12 - Host records zero-phase reference channel
// RL13 - High gain register at 11h, resets 8000h
// RL14 - Writes to read-only fields are ignored
`timescale 1ns/1ps
module acr_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Serial port from host
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        din,
  // Serial data out, three-state
  output logic             doutOut,
  output logic             doutOe,
  // Gain word to the channel 1 datapath
  output logic [23:0]      ch1GainWord
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pinSync;
  logic       csNS;
  logic       sclkS;
  logic       dinS;
  logic       sclkPrev_q;
  logic       csNPrev_q;
  logic       sclkRise;
  logic       sclkFall;
  logic       frameStart;

  // Select enters inverted so the select chain, like the clock chain, idles at its reset level,
  // which keeps the edge detectors from seeing a false edge after reset
  acr_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk    (ref_clk),
    .reset  (reset),
    .async  ({~csN, sclk, din}),
    .synced (pinSync)
  );

  assign csNS       = ~pinSync[2];
  assign sclkS      = pinSync[1];
  assign dinS       = pinSync[0];
  assign sclkRise   = sclkS & ~sclkPrev_q;
  assign sclkFall   = ~sclkS & sclkPrev_q;
  assign frameStart = ~csNS & csNPrev_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclkPrev_q <= 1'b0;
      csNPrev_q  <= 1'b1;
    end else begin
      sclkPrev_q <= sclkS;
      csNPrev_q  <= csNS;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  acr_pkg::acr_phase_t phase_q;
  logic [4:0]          bitCnt_q;
  logic [15:0]         inShift_q;
  logic [15:0]         cmd_q;
  logic                lastCmdBit;
  logic                lastBit;
  logic                commit;

  assign lastCmdBit = sclkFall && (phase_q == acr_pkg::PH_CMD)
                      && (bitCnt_q == acr_pkg::LAST_CMD_BIT);
  assign lastBit    = sclkFall && (phase_q == acr_pkg::PH_DATA)
                      && (bitCnt_q == acr_pkg::LAST_FRAME_BIT);
  assign commit     = lastBit && cmd_q[acr_pkg::CMD_WRITE_BIT];

  // Chip select release aborts a partial frame; nothing is written
  always_ff @(posedge ref_clk) begin
    if (reset || csNS) begin
      phase_q <= acr_pkg::PH_IDLE;
    end else begin
      unique case (phase_q)
        acr_pkg::PH_IDLE: begin
          if (frameStart) begin
            phase_q <= acr_pkg::PH_CMD;
          end
        end
        acr_pkg::PH_CMD: begin
          if (lastCmdBit) begin
            phase_q <= acr_pkg::PH_DATA;
          end
        end
        acr_pkg::PH_DATA: begin
          if (lastBit) begin
            phase_q <= acr_pkg::PH_DONE;
          end
        end
        acr_pkg::PH_DONE: begin
          phase_q <= acr_pkg::PH_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || frameStart) begin
      bitCnt_q  <= 5'h00;
      inShift_q <= 16'h0000;
    end else if (sclkFall && (phase_q == acr_pkg::PH_CMD || phase_q == acr_pkg::PH_DATA)) begin
      bitCnt_q  <= bitCnt_q + 5'h01;
      inShift_q <= {inShift_q[14:0], dinS};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_q <= 16'h0000;
    end else if (lastCmdBit) begin
      cmd_q <= {inShift_q[14:0], dinS};
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] gainHigh_q;
  logic [7:0]  gainLow_q;
  logic [15:0] spare_q;
  logic [15:0] mapCrc_q;
  logic        crcDue_q;
  logic [15:0] wrData;
  logic [5:0]  wrAddr;

  assign wrData = {inShift_q[14:0], dinS};
  assign wrAddr = cmd_q[acr_pkg::CMD_ADDR_MSB:acr_pkg::CMD_ADDR_LSB];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gainHigh_q <= acr_pkg::RST_GAIN_HIGH;  // [RL13]
    end else if (commit && wrAddr == acr_pkg::ADDR_GAIN_HIGH) begin
      gainHigh_q <= wrData;  // [RL1]
    end
  end

  // Only the upper byte is stored; the low byte is never written [RL14]
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gainLow_q <= acr_pkg::RST_GAIN_LOW;
    end else if (commit && wrAddr == acr_pkg::ADDR_GAIN_LOW) begin
      gainLow_q <= wrData[acr_pkg::LOW_FIELD_MSB:acr_pkg::LOW_FIELD_LSB];  // [RL2]
    end
  end

  // Stored as written; keeping it zero is the host's duty
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      spare_q <= acr_pkg::RST_SPARE;
    end else if (commit && wrAddr == acr_pkg::ADDR_SPARE) begin
      spare_q <= wrData;  // [RL4]
    end
  end

  // Gain word moves on ref_clk only, in step with peers on that clock [RL11]
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ch1GainWord <= {acr_pkg::RST_GAIN_HIGH, acr_pkg::RST_GAIN_LOW};
    end else begin
      ch1GainWord <= {gainHigh_q, gainLow_q};  // [RL1] [RL2]
    end
  end

  // ----------------------------------------------------------------
  // Register-map checksum
  // ----------------------------------------------------------------
  // Recomputed the cycle after any committed write, so it stays zero
  // from reset until software first touches the map.
  function automatic logic [15:0] crcWord(input logic [15:0] seed,
                                          input logic [15:0] word);
    logic [15:0] c;
    logic        fb;
    c = seed;
    for (int i = acr_pkg::WORD_BITS - 1; i >= 0; i--) begin
      fb = c[15] ^ word[i];
      c  = {c[14:0], 1'b0} ^ (fb ? acr_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crcDue_q <= 1'b0;
    end else begin
      crcDue_q <= commit;
    end
  end

  // Writes to the checksum address never reach this register [RL14]
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mapCrc_q <= acr_pkg::RST_MAP_CRC;  // [RL3]
    end else if (crcDue_q) begin
      mapCrc_q <= crcWord(crcWord(crcWord(acr_pkg::CRC_SEED, gainHigh_q),
                                  {gainLow_q, acr_pkg::LOW_RSVD_VALUE}), spare_q);  // [RL3]
    end
  end

  // ----------------------------------------------------------------
  // Read path and data out
  // ----------------------------------------------------------------
  logic [15:0] rdData;
  logic [5:0]  rdAddr;
  logic [15:0] outShift_q;

  assign rdAddr = wrData[acr_pkg::CMD_ADDR_MSB:acr_pkg::CMD_ADDR_LSB];

  // Unmapped addresses read as zero
  always_comb begin
    unique case (rdAddr)
      acr_pkg::ADDR_GAIN_HIGH: rdData = gainHigh_q;  // [RL1]
      acr_pkg::ADDR_GAIN_LOW:  rdData = {gainLow_q, acr_pkg::LOW_RSVD_VALUE};  // [RL2]
      acr_pkg::ADDR_MAP_CRC:   rdData = mapCrc_q;  // [RL3]
      acr_pkg::ADDR_SPARE:     rdData = spare_q;
      default:                 rdData = 16'h0000;
    endcase
  end

  // First data bit goes out right after the command; the rest on rising edges
  always_ff @(posedge ref_clk) begin
    if (reset || frameStart) begin
      outShift_q <= 16'h0000;
      doutOut    <= 1'b0;
    end else if (lastCmdBit) begin
      outShift_q <= wrData[acr_pkg::CMD_WRITE_BIT] ? 16'h0000 : {rdData[14:0], 1'b0};
      doutOut    <= wrData[acr_pkg::CMD_WRITE_BIT] ? 1'b0 : rdData[15];
    end else if (sclkRise && phase_q == acr_pkg::PH_DATA) begin
      outShift_q <= {outShift_q[14:0], 1'b0};
      doutOut    <= outShift_q[15];
    end
  end

  // Line is released while deselected so others can share it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      doutOe <= 1'b0;
    end else begin
      doutOe <= ~csNS;  // [RL5]
    end
  end

endmodule

//--- sim/acr_regs_asserts.sv
// Port checker for the gain / checksum register bank.
// Assumes ref_clk domain only, synchronous active-high reset.
`timescale 1ns/1ps
module acr_regs_asserts (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Serial port
  input  wire logic        csN,
  input  wire logic        doutOut,
  input  wire logic        doutOe,
  // Datapath feed
  input  wire logic [23:0] ch1GainWord
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // --------------------------------------------------------------
  // Frame phases
  // --------------------------------------------------------------
  sequence idle_s;
    csN[*8];
  endsequence
  sequence busy_s;
    !csN[*4];
  endsequence
  quiet_line_a: assert property (idle_s |-> !doutOe)
    else $error("data out driven while deselected");
  drive_sel_a: assert property (busy_s |-> doutOe)
    else $error("data out not driven in frame");
  oe_release_a: assert property ($rose(csN) |-> ##[1:4] !doutOe)
    else $error("data out not released after deselect");
  gain_default_a: assert property ($fell(reset) |-> ch1GainWord == 24'h800000)
    else $error("gain word not unity after reset");
  out_reset_a: assert property ($fell(reset) |-> !doutOe && !doutOut)
    else $error("data out active after reset");
  gain_hold_a: assert property (idle_s |=> $stable(ch1GainWord))
    else $error("gain word moved outside a frame");
endmodule
bind acr_regs acr_regs_asserts chk (
  .ref_clk    (ref_clk),
  .reset      (reset),
  .csN        (csN),
  .doutOut    (doutOut),
  .doutOe     (doutOe),
  .ch1GainWord(ch1GainWord)
);

//--- sim/acr_host_model.sv
// Host controller model: drives select, serial clock and data in.
// Assumes a 320 ns serial clock built from ref_clk, sclk idle low.
`timescale 1ns/1ps
module acr_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial port to the device
  output logic      csN,
  output logic      sclk,
  output logic      din,
  // Data from the device
  input  wire logic doutOut
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // --------------------------------------------------------------
  // Frame of nBits clocks; fewer than 32 aborts
  // --------------------------------------------------------------
  // Single device, own select only, never two low
  // No sync, ready or phase pins here; timing rests on counting
  task automatic xfer(input logic [31:0] frame, input int nBits, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge ref_clk);
    // Select dropped per frame; tying it low is allowed when alone, but the device then takes only the first frame after reset
    csN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < nBits; i++) begin
      // Bit stands since the last change; take it before raising the clock
      if (i >= 16) rd = {rd[14:0], doutOut};
      sclk <= 1'b1;
      din <= frame[31-i];
      // Serial clock paced by counting ref_clk cycles
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    csN <= 1'b1;
    // Released line flips so a stale bit never looks valid
    din <= ~din;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

//--- sim/acr_regs_tb.sv
// Self-checking bench for the gain / checksum register bank.
// Assumes acr_host_model as the serial host and the bound checker.
`timescale 1ns/1ps
module acr_regs_tb;
  logic        ref_clk;
  logic        reset;
  logic        csN;
  logic        sclk;
  logic        din;
  logic        doutOut;
  logic        doutOe;
  logic        doutLine;
  logic [23:0] ch1GainWord;
  logic [15:0] rd;
  logic [15:0] hi;
  logic [15:0] lo;
  int          fail_count;
  int          n_tests;
  int          seed;
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Released line shows the inverse, so a read of an undriven line fails
  assign doutLine = doutOe ? doutOut : ~doutOut;
  // Device and host run from one shared clock
  acr_regs dut (
    .ref_clk(ref_clk), .reset(reset), .csN(csN), .sclk(sclk), .din(din),
    .doutOut(doutOut), .doutOe(doutOe), .ch1GainWord(ch1GainWord)
  );
  acr_host_model host (
    .ref_clk(ref_clk), .csN(csN), .sclk(sclk), .din(din), .doutOut(doutLine)
  );
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [47:0] msg);
    logic [15:0] c;
    c = acr_pkg::CRC_SEED;
    for (int i = 47; i >= 0; i--) begin
      c = (c[15] ^ msg[i]) ? ({c[14:0], 1'b0} ^ acr_pkg::CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({2'b10, a, 8'h00, d}, 32, rd);
  endtask
  task rdchk(input logic [5:0] a, input logic [15:0] exp);
    host.xfer({2'b00, a, 8'h00, 16'h0000}, 32, rd);
    check({8'h00, rd}, {8'h00, exp});
  endtask
  task test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    test_done;
  end
  initial begin
    seed = 32'h4da630b5;
    reset = 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(ch1GainWord, 24'h800000);
    rdchk(acr_pkg::ADDR_GAIN_HIGH, 16'h8000);
    rdchk(acr_pkg::ADDR_GAIN_LOW, 16'h0000);
    rdchk(acr_pkg::ADDR_MAP_CRC, 16'h0000);
    rdchk(acr_pkg::ADDR_SPARE, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      {hi, lo} = $random(seed);
      if (k == 0) {hi, lo} = 32'hffffffff;
      wr(acr_pkg::ADDR_GAIN_HIGH, hi);
      wr(acr_pkg::ADDR_GAIN_LOW, lo);
      lo[7:0] = 8'h00;
      check(ch1GainWord, {hi, lo[15:8]});
      rdchk(acr_pkg::ADDR_GAIN_HIGH, hi);
      rdchk(acr_pkg::ADDR_GAIN_LOW, lo);
      wr(acr_pkg::ADDR_MAP_CRC, ~hi);
      rdchk(acr_pkg::ADDR_MAP_CRC, crc16({hi, lo, 16'h0000}));
    end
    // Frame cut short after 24 clocks must leave the register alone
    host.xfer({2'b10, acr_pkg::ADDR_GAIN_HIGH, 8'h00, 16'h1357}, 24, rd);
    rdchk(acr_pkg::ADDR_GAIN_HIGH, hi);
    wr(acr_pkg::ADDR_SPARE, 16'h0000);
    rdchk(acr_pkg::ADDR_SPARE, 16'h0000);
    rdchk(6'h20, 16'h0000);
    check({23'h0, doutOe}, 24'h000000);
    // Mid-run reset must bring back the defaults over written values
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(ch1GainWord, 24'h800000);
    rdchk(acr_pkg::ADDR_GAIN_HIGH, 16'h8000);
    rdchk(acr_pkg::ADDR_MAP_CRC, 16'h0000);
    test_done;
  end
endmodule
